// File: core/sacs_store.sv
// Configuration store for the three-axis stage controller.
// What this block does
// [RL1] Host must power-cycle before relying on changed settings; applied at start-up. Profile speeds and ramp here apply at once.
// [RL2] Active profile at power-on comes from stored preset 1..4, default 1.
// [RL3] Four profiles hold min and max speed, range 1..999999999.
// [RL4] Each profile holds a ramp time 1..1000 ms.
// [RL5] Host keeps each profile's minimum speed below its maximum.
// [RL6] Joystick and stored-program moves use the selected profile.
// [RL7] Output polarity: active-high rests low, active-low rests high; default active-high.
// [RL8] Baud 9600, 38400 or 57600, default 38400, both ends equal.
// [RL9] Per-axis display unit pulse, micrometre or degree, default micrometre.
// [RL10] Per-axis travel per step 1..1000000 in 0.1 nm, default 1000.
// [RL11] Degree axes read travel per step as millionths of a degree.
// [RL12] Travel-per-step calibration assumes a microstep division of 40.
// [RL13] Per-axis direction sense, forward by default.
// [RL14] Per-axis home method 0..6, none is 0, default 1.
// [RL15] Home offset 0..999999999 applied only for methods 1, 5, 6.
// [RL16] A stored zero offset means half a millimetre.
// [RL17] Per-axis automatic setup, enabled by default.
// [RL18] Methods 5 and 6 use the driver index pulse, no sensor.
// [RL19] Method none performs no search and keeps the position reference.
// [RL20] Out-of-range writes are rejected and the old value kept.
`timescale 1ns/10ps
module sacs_store
  import sacs_pkg::*;
(
  input  wire logic        clock,                  // System clock, 250 MHz.
  input  wire logic        rst_n,                  // Asynchronous reset, active low.
  input  wire logic        wr_valid,               // Write strobe for one item.
  input  wire sacs_wr_s    wr_data,                // Item selector, index and value.
  output logic             wr_ack,                 // Write accepted and stored.
  output logic             wr_reject,              // Write refused, value out of range.
  input  wire logic        start_up,               // Start-up pulse: apply stored settings.
  input  wire logic        io_assert [4],          // Logical I/O output assertions.
  output logic             io_pin [4],             // I/O output pin levels after polarity.
  output sacs_baud_e       baud_select,            // Applied serial rate.
  output sacs_prof_s       active_profile,         // Profile for joystick and program moves.
  output logic [1:0]       active_preset,          // Applied preset index, zero based.
  output sacs_axis_s       axis_cfg [NUM_AXES],    // Applied per-axis settings.
  output logic [29:0]      axis_eff_offset [NUM_AXES], // Offset applied at home return.
  output logic             axis_uses_index [NUM_AXES], // Home by driver index pulse.
  output logic             axis_home_search [NUM_AXES] // Home request searches at all.
);

  // ----------------------------------------
  // Stored settings
  // ----------------------------------------
  logic [1:0]  preset_r;
  sacs_prof_s  prof_r [NUM_PROFILES];
  sacs_pol_e   pol_r;
  sacs_baud_e  baud_r;
  sacs_axis_s  axis_r [NUM_AXES];

  // Applied settings, latched on start-up only.
  logic [1:0]  act_preset_r;
  sacs_pol_e   act_pol_r;
  sacs_baud_e  act_baud_r;
  sacs_axis_s  act_axis_r [NUM_AXES];
  logic        wr_ack_r;
  logic        wr_reject_r;
  logic [29:0] eff_offset_r [NUM_AXES];
  logic        uses_index_r [NUM_AXES];
  logic        home_search_r [NUM_AXES];

  function automatic logic in_range30(input logic [29:0] v, input logic [29:0] lo,
                                      input logic [29:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  function automatic sacs_axis_s axis_default();
    sacs_axis_s a;
    a.unit            = UNIT_MICRO;
    a.travel_per_step = STEP_DEFAULT;
    a.reverse         = 1'b0;
    a.home            = home_method_one;
    a.home_offset     = '0;
    a.auto_setup      = 1'b1;
    return a;
  endfunction

  // Reset image of one axis, a constant so that reset branches assign constants only.
  localparam sacs_axis_s AXIS_RESET = axis_default();

  // [RL18] index pulse methods
  function automatic logic uses_index_of(input sacs_axis_s a);
    return a.home inside {home_method_index_minus, home_method_index_plus};
  endfunction

  // [RL15] offset only 1, 5, 6
  // [RL16] zero gives half millimetre
  function automatic logic [29:0] eff_offset_of(input sacs_axis_s a);
    return ((a.home != home_method_one) && !uses_index_of(a)) ? '0 :
           (a.home_offset == '0) ? OFFSET_ZERO_SUBST : a.home_offset;
  endfunction

  // ----------------------------------------
  // Write decode and range check
  // ----------------------------------------
  wire logic [29:0] v         = wr_data.value;
  wire logic [1:0]  idx       = wr_data.index;
  wire logic        axis_ok   = idx < 2'(NUM_AXES);
  // Range checks, invalid values refused
  // [RL20] reject out of range
  wire logic ok_preset = v <= 30'(NUM_PROFILES - 1);
  // [RL3] speed range check
  wire logic ok_speed  = in_range30(v, SPEED_MIN, SPEED_MAX);
  // [RL4] ramp range check
  wire logic ok_ramp   = in_range30(v, 30'(RAMP_MIN), 30'(RAMP_MAX));
  // [RL8] legal baud codes
  wire logic ok_baud   = v <= 30'(BAUD_57600);
  // [RL9] legal unit codes
  wire logic ok_unit   = axis_ok && (v <= 30'(UNIT_DEGREE));
  // [RL10] step range check
  wire logic ok_step   = axis_ok && in_range30(v, 30'(STEP_MIN), 30'(STEP_MAX));
  // [RL14] seven home codes
  wire logic ok_home   = axis_ok && (v <= 30'(home_method_index_plus));
  // [RL15] offset range check
  wire logic ok_offset = axis_ok && (v <= OFFSET_MAX);
  wire logic ok_bit    = v <= 30'h0000_0001;

  logic accept;
  always_comb begin
    unique case (wr_data.sel)
      SEL_PRESET:   accept = ok_preset;
      SEL_MIN:      accept = ok_speed;
      SEL_MAX:      accept = ok_speed;
      SEL_RAMP:     accept = ok_ramp;
      SEL_POLARITY: accept = ok_bit;
      SEL_BAUD:     accept = ok_baud;
      SEL_UNIT:     accept = ok_unit;
      SEL_STEP:     accept = ok_step;
      SEL_DIR:      accept = axis_ok && ok_bit;
      SEL_HOME:     accept = ok_home;
      SEL_OFFSET:   accept = ok_offset;
      SEL_AUTO:     accept = axis_ok && ok_bit;
      default:      accept = 1'b0;
    endcase
  end

  wire logic do_wr = wr_valid && accept;

  // ----------------------------------------
  // Write enables, one per item
  // ----------------------------------------
  // Only accepted writes reach a register; a refused one leaves every setting as it was.
  wire logic wr_preset   = do_wr && (wr_data.sel == SEL_PRESET);
  wire logic wr_min      = do_wr && (wr_data.sel == SEL_MIN);
  wire logic wr_max      = do_wr && (wr_data.sel == SEL_MAX);
  wire logic wr_ramp     = do_wr && (wr_data.sel == SEL_RAMP);
  wire logic wr_polarity = do_wr && (wr_data.sel == SEL_POLARITY);
  wire logic wr_baud     = do_wr && (wr_data.sel == SEL_BAUD);
  wire logic wr_unit     = do_wr && (wr_data.sel == SEL_UNIT);
  wire logic wr_step     = do_wr && (wr_data.sel == SEL_STEP);
  wire logic wr_dir      = do_wr && (wr_data.sel == SEL_DIR);
  wire logic wr_home     = do_wr && (wr_data.sel == SEL_HOME);
  wire logic wr_offset   = do_wr && (wr_data.sel == SEL_OFFSET);
  wire logic wr_auto     = do_wr && (wr_data.sel == SEL_AUTO);

  // ----------------------------------------
  // Stored value registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // [RL2] default preset one
      preset_r <= PRESET_DEFAULT;
      // [RL7] default active high
      pol_r    <= assert_high_polarity;
      // [RL8] default 38400
      baud_r   <= BAUD_38400;
    end else begin
      if (wr_preset) begin
        preset_r <= v[1:0];
      end
      if (wr_polarity) begin
        pol_r <= sacs_pol_e'(v[0]);
      end
      if (wr_baud) begin
        baud_r <= sacs_baud_e'(v[1:0]);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < NUM_PROFILES; p++) begin
        prof_r[p] <= '{PROF_MIN_DEFAULT[p], PROF_MAX_DEFAULT[p], RAMP_DEFAULT};
      end
    end else begin
      if (wr_min) begin
        prof_r[idx].min_speed <= v;
      end
      if (wr_max) begin
        prof_r[idx].max_speed <= v;
      end
      if (wr_ramp) begin
        prof_r[idx].ramp_ms <= v[9:0];
      end
    end
  end

  // An axis index of three never gets here: the range check refuses it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        // [RL17] per-axis defaults
        axis_r[a] <= AXIS_RESET;
      end
    end else begin
      if (wr_unit) begin
        axis_r[idx].unit <= sacs_unit_e'(v[1:0]);
      end
      if (wr_step) begin
        axis_r[idx].travel_per_step <= v[19:0];
      end
      // [RL13] direction sense store
      if (wr_dir) begin
        axis_r[idx].reverse <= v[0];
      end
      if (wr_home) begin
        axis_r[idx].home <= sacs_home_e'(v[2:0]);
      end
      if (wr_offset) begin
        axis_r[idx].home_offset <= v;
      end
      if (wr_auto) begin
        axis_r[idx].auto_setup <= v[0];
      end
    end
  end

  // ----------------------------------------
  // Start-up application
  // ----------------------------------------
  // [RL1] apply on start-up
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      act_preset_r <= PRESET_DEFAULT;
      act_pol_r    <= assert_high_polarity;
      act_baud_r   <= BAUD_38400;
      for (int a = 0; a < NUM_AXES; a++) begin
        act_axis_r[a] <= AXIS_RESET;
      end
    end else if (start_up) begin
      act_preset_r <= preset_r;
      act_pol_r    <= pol_r;
      act_baud_r   <= baud_r;
      act_axis_r   <= axis_r;
    end
  end

  // Home decode is latched with the axis settings, so it changes together with axis_cfg.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        // [RL16] default method one, zero offset
        eff_offset_r[a]  <= OFFSET_ZERO_SUBST;
        uses_index_r[a]  <= 1'b0;
        home_search_r[a] <= 1'b1;
      end
    end else if (start_up) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        eff_offset_r[a]  <= eff_offset_of(axis_r[a]);
        uses_index_r[a]  <= uses_index_of(axis_r[a]);
        // [RL19] search unless none
        home_search_r[a] <= axis_r[a].home != home_method_none;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ack_r    <= 1'b0;
      wr_reject_r <= 1'b0;
    end else begin
      wr_ack_r    <= do_wr;
      wr_reject_r <= wr_valid && !accept;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wr_ack        = wr_ack_r;
  assign wr_reject     = wr_reject_r;
  assign baud_select   = act_baud_r;
  assign active_preset = act_preset_r;
  // [RL6] selected profile out
  assign active_profile = prof_r[act_preset_r];

  // [RL7] polarity on pins
  for (genvar i = 0; i < 4; i++) begin : g_io
    assign io_pin[i] = io_assert[i] ^ (act_pol_r == assert_low_polarity);
  end

  // Travel per step is passed as stored; its unit depends on the display unit
  // (0.1 nm, or millionths of a degree) and assumes a fixed microstep division.
  // [RL11] degree interpretation
  // [RL12] fixed division forty
  for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
    assign axis_cfg[a] = act_axis_r[a];
    // [RL15] offset for 1, 5, 6
    // [RL16] zero means 0.5 mm
    assign axis_eff_offset[a] = eff_offset_r[a];
    // [RL18] index pulse homing
    assign axis_uses_index[a] = uses_index_r[a];
    // [RL19] no search for none
    assign axis_home_search[a] = home_search_r[a];
  end

endmodule

// File: core/sacs_pkg.sv
// Package of constants and types for the stage axis configuration store.
package sacs_pkg;
  // ----------------------------------------
  // Field widths and ranges
  // ----------------------------------------
  localparam int         NUM_AXES     = 3;
  localparam int         NUM_PROFILES = 4;
  localparam logic [29:0] SPEED_MIN   = 30'h0000_0001;
  localparam logic [29:0] SPEED_MAX   = 30'h3B9A_C9FF;
  localparam logic [9:0]  RAMP_MIN    = 10'h001;
  localparam logic [9:0]  RAMP_MAX    = 10'h3E8;
  localparam logic [19:0] STEP_MIN    = 20'h00001;
  localparam logic [19:0] STEP_MAX    = 20'hF4240;
  localparam logic [29:0] OFFSET_MAX  = 30'h3B9A_C9FF;
  // Zero offset stands for half a millimetre, in 0.01 um units.
  localparam logic [29:0] OFFSET_ZERO_SUBST = 30'h0000_C350;
  localparam int         MICROSTEP_DIV = 40;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [1:0]  PRESET_DEFAULT = 2'h0;
  localparam logic [19:0] STEP_DEFAULT   = 20'h003E8;
  localparam logic [9:0]  RAMP_DEFAULT   = 10'h0C8;
  localparam logic [29:0] PROF_MIN_DEFAULT [NUM_PROFILES] =
    '{30'h0000_2710, 30'h0000_7530, 30'h0001_1170, 30'h0001_86A0};
  localparam logic [29:0] PROF_MAX_DEFAULT [NUM_PROFILES] =
    '{30'h0001_86A0, 30'h0004_93E0, 30'h000A_AE60, 30'h000F_4240};

  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {BAUD_9600, BAUD_38400, BAUD_57600} sacs_baud_e;
  typedef enum logic [1:0] {UNIT_PULSE, UNIT_MICRO, UNIT_DEGREE} sacs_unit_e;
  typedef enum logic [0:0] {assert_high_polarity, assert_low_polarity} sacs_pol_e;
  typedef enum logic [2:0] {
    home_method_none, home_method_one, home_code_midpoint, home_code_three_sensor,
    home_code_four_sensor, home_method_index_minus, home_method_index_plus
  } sacs_home_e;

  // Selector of the item that a write targets.
  typedef enum logic [3:0] {
    SEL_PRESET, SEL_MIN, SEL_MAX, SEL_RAMP, SEL_POLARITY, SEL_BAUD,
    SEL_UNIT, SEL_STEP, SEL_DIR, SEL_HOME, SEL_OFFSET, SEL_AUTO
  } sacs_sel_e;

  typedef struct packed {
    logic [29:0] min_speed;
    logic [29:0] max_speed;
    logic [9:0]  ramp_ms;
  } sacs_prof_s;

  typedef struct packed {
    sacs_unit_e  unit;
    logic [19:0] travel_per_step;
    logic        reverse;
    sacs_home_e  home;
    logic [29:0] home_offset;
    logic        auto_setup;
  } sacs_axis_s;

  typedef struct packed {
    sacs_sel_e   sel;
    logic [1:0]  index;
    logic [29:0] value;
  } sacs_wr_s;
endpackage

// File: testbench/sacs_store_properties.sv
// Port relations of the stage axis configuration store.
`timescale 1ns/10ps
module sacs_store_properties
  import sacs_pkg::*;
(
  input wire logic        clock,                       // Clock.
  input wire logic        rst_n,                       // Reset.
  input wire logic        wr_valid,                    // Strobe.
  input wire sacs_wr_s    wr_data,                     // Item.
  input wire logic        wr_ack,                      // Stored.
  input wire logic        wr_reject,                   // Refused.
  input wire logic        start_up,                    // Apply.
  input wire logic        io_assert [4],               // Logical.
  input wire logic        io_pin [4],                  // Pins.
  input wire sacs_baud_e  baud_select,                 // Rate.
  input wire sacs_prof_s  active_profile,              // Profile.
  input wire logic [1:0]  active_preset,               // Preset.
  input wire sacs_axis_s  axis_cfg [NUM_AXES],         // Axes.
  input wire logic [29:0] axis_eff_offset [NUM_AXES],  // Offsets.
  input wire logic        axis_uses_index [NUM_AXES],  // Index.
  input wire logic        axis_home_search [NUM_AXES]  // Search.
);
  wire logic       pol_w = io_pin[0] ^ io_assert[0];
  wire sacs_home_e h0    = axis_cfg[0].home;
  wire logic       off_w = h0 inside {home_method_one, home_method_index_minus,
                                      home_method_index_plus};
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  a_write_answer: assert property (wr_valid |=> wr_ack ^ wr_reject)
    else $error("write not answered");
  a_idle_silent: assert property (!wr_valid |=> !(wr_ack || wr_reject))
    else $error("answer without write");
  a_pol_uniform: assert property (pol_w == (io_pin[3] ^ io_assert[3]))
    else $error("pins disagree on polarity");
  a_pol_latched: assert property (!start_up |=> $stable(pol_w))
    else $error("polarity changed without start-up");
  a_baud_latched: assert property (!start_up |=> $stable(baud_select))
    else $error("rate changed without start-up");
  a_preset_held: assert property (!start_up |=> $stable(active_preset))
    else $error("preset changed without start-up");
  a_offset_gate: assert property (!off_w |-> axis_eff_offset[0] == 30'h0)
    else $error("offset applied for wrong method");
  a_zero_offset: assert property (off_w && axis_cfg[0].home_offset == 30'h0 |->
    axis_eff_offset[0] == OFFSET_ZERO_SUBST)
    else $error("zero offset not substituted");
  a_index_home: assert property (axis_uses_index[0] == (h0 > home_code_four_sensor))
    else $error("index homing flag wrong");
  a_home_search: assert property (axis_home_search[0] == (h0 != home_method_none))
    else $error("home search flag wrong");
  c_ack: cover property (wr_ack);
  c_reject: cover property (wr_reject);
  c_apply: cover property (start_up ##1 active_preset != 2'h0);
endmodule
bind sacs_store sacs_store_properties u_props (.clock(clock), .rst_n(rst_n),
  .wr_valid(wr_valid), .wr_data(wr_data), .wr_ack(wr_ack), .wr_reject(wr_reject),
  .start_up(start_up), .io_assert(io_assert), .io_pin(io_pin), .baud_select(baud_select),
  .active_profile(active_profile), .active_preset(active_preset), .axis_cfg(axis_cfg),
  .axis_eff_offset(axis_eff_offset), .axis_uses_index(axis_uses_index),
  .axis_home_search(axis_home_search));

// File: testbench/sacs_host.sv
// Host model that writes configuration items and restarts the store.
`timescale 1ns/10ps
module sacs_host
  import sacs_pkg::*;
(
  input  wire logic clock,     // Clock.
  input  wire logic wr_ack,    // Stored.
  input  wire logic wr_reject, // Refused.
  output logic      wr_valid,  // Strobe.
  output sacs_wr_s  wr_data,   // Item.
  output logic      start_up   // Apply.
);
  initial begin
    wr_valid = 1'b0;
    wr_data  = '0;
    start_up = 1'b0;
  end
  task automatic put(input sacs_wr_s w, input logic last, output logic [1:0] res);
    wr_valid = 1'b1;
    wr_data  = w;
    @(negedge clock);
    res = {wr_ack, wr_reject};
    if (last) begin
      wr_valid = 1'b0;
      wr_data  = ~w;
    end
  endtask
  task automatic pulse();
    start_up = 1'b1;
    @(negedge clock);
    start_up = 1'b0;
    @(negedge clock);
  endtask
endmodule

// File: testbench/sacs_store_tb.sv
// Self-checking bench for the stage axis configuration store.
`timescale 1ns/10ps
module sacs_store_tb;
  import sacs_pkg::*;
  typedef struct packed {sacs_wr_s w; logic rej;} sacs_row_s;
  logic        clock, rst_n, wr_valid, wr_ack, wr_reject, start_up;
  sacs_wr_s    wr_data;
  logic        io_assert [4];
  logic        io_pin [4];
  sacs_baud_e  baud_select;
  sacs_prof_s  active_profile;
  logic [1:0]  active_preset, res;
  sacs_axis_s  axis_cfg [NUM_AXES];
  logic [29:0] axis_eff_offset [NUM_AXES];
  logic        axis_uses_index [NUM_AXES];
  logic        axis_home_search [NUM_AXES];
  int          n_mismatch = 0;
  int          checked = 0;
  localparam sacs_axis_s AX_DEF = '{UNIT_MICRO, 20'h003E8, 1'b0, home_method_one, 30'h0, 1'b1};
  localparam sacs_axis_s AX0_EXP = '{UNIT_MICRO, 20'hF4240, 1'b0, home_method_one, 30'h0, 1'b1};
  localparam sacs_axis_s AX1_EXP = '{UNIT_DEGREE, 20'h003E8, 1'b1, home_method_one, 30'h0, 1'b0};
  sacs_row_s   rows [20] = '{
    '{'{SEL_PRESET, 2'h0, 30'h2}, 1'b0}, '{'{SEL_PRESET, 2'h0, 30'h4}, 1'b1},
    '{'{SEL_MIN, 2'h2, 30'h5}, 1'b0}, '{'{SEL_MIN, 2'h2, 30'h0}, 1'b1},
    '{'{SEL_MAX, 2'h2, 30'h3B9AC9FF}, 1'b0}, '{'{SEL_MAX, 2'h2, 30'h3B9ACA00}, 1'b1},
    '{'{SEL_RAMP, 2'h2, 30'h3E8}, 1'b0}, '{'{SEL_RAMP, 2'h2, 30'h3E9}, 1'b1},
    '{'{SEL_POLARITY, 2'h0, 30'h1}, 1'b0}, '{'{SEL_POLARITY, 2'h0, 30'h2}, 1'b1},
    '{'{SEL_BAUD, 2'h0, 30'h3}, 1'b1}, '{'{SEL_UNIT, 2'h1, 30'h2}, 1'b0},
    '{'{SEL_UNIT, 2'h1, 30'h3}, 1'b1}, '{'{SEL_STEP, 2'h0, 30'hF4240}, 1'b0},
    '{'{SEL_STEP, 2'h0, 30'hF4241}, 1'b1}, '{'{SEL_STEP, 2'h3, 30'h1}, 1'b1},
    '{'{SEL_DIR, 2'h1, 30'h1}, 1'b0}, '{'{SEL_HOME, 2'h2, 30'h7}, 1'b1},
    '{'{SEL_OFFSET, 2'h2, 30'h3B9AC9FF}, 1'b0}, '{'{SEL_AUTO, 2'h1, 30'h0}, 1'b0}};
  sacs_store u_dut (.clock(clock), .rst_n(rst_n), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_ack(wr_ack), .wr_reject(wr_reject), .start_up(start_up), .io_assert(io_assert),
    .io_pin(io_pin), .baud_select(baud_select), .active_profile(active_profile),
    .active_preset(active_preset), .axis_cfg(axis_cfg), .axis_eff_offset(axis_eff_offset),
    .axis_uses_index(axis_uses_index), .axis_home_search(axis_home_search));
  sacs_host u_host (.clock(clock), .wr_ack(wr_ack), .wr_reject(wr_reject),
    .wr_valid(wr_valid), .wr_data(wr_data), .start_up(start_up));
  task automatic chk(input string what, input logic [69:0] exp, input logic [69:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    repeat (3000) @(posedge clock);
    n_mismatch++;
    summarize();
  end
  initial begin
    rst_n = 1'b0;
    io_assert = '{default: 1'b0};
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    chk("preset", 70'h0, 70'(active_preset));
    chk("baud", 70'(BAUD_38400), 70'(baud_select));
    chk("prof", {30'h2710, 30'h186A0, 10'h0C8}, active_profile);
    chk("axis", 70'(AX_DEF), 70'(axis_cfg[2]));
    chk("pin", 70'h0, 70'(io_pin[1]));
    foreach (rows[i]) begin
      u_host.put(rows[i].w, i == $high(rows), res);
      chk("answer", 70'({~rows[i].rej, rows[i].rej}), 70'(res));
    end
    chk("preset", 70'h0, 70'(active_preset));
    io_assert = '{1'b1, 1'b0, 1'b1, 1'b0};
    u_host.pulse();
    chk("preset", 70'h2, 70'(active_preset));
    chk("prof", {30'h5, 30'h3B9AC9FF, 10'h3E8}, active_profile);
    chk("pin0", 70'h0, 70'(io_pin[0]));
    chk("pin1", 70'h1, 70'(io_pin[1]));
    chk("axis0", 70'(AX0_EXP), 70'(axis_cfg[0]));
    chk("axis1", 70'(AX1_EXP), 70'(axis_cfg[1]));
    chk("eoff2", 70'h3B9AC9FF, 70'(axis_eff_offset[2]));
    u_host.put('{SEL_MAX, 2'h2, 30'h100}, 1'b0, res);
    chk("answer", 70'h2, 70'(res));
    u_host.put('{SEL_MIN, 2'h2, 30'h40}, 1'b1, res);
    chk("live", {30'h40, 30'h100, 10'h3E8}, active_profile);
    for (int i = 0; i < 7; i++) begin
      u_host.put('{SEL_HOME, 2'h0, 30'(i)}, 1'b0, res);
      u_host.put('{SEL_BAUD, 2'h0, 30'(i % 3)}, 1'b1, res);
      u_host.pulse();
      chk("home", 70'(i), 70'(axis_cfg[0].home));
      chk("search", 70'(i != 0), 70'(axis_home_search[0]));
      chk("index", 70'(i > 4), 70'(axis_uses_index[0]));
      chk("eoff0", (i == 1 || i > 4) ? 70'hC350 : 70'h0, 70'(axis_eff_offset[0]));
      chk("baud", 70'(i % 3), 70'(baud_select));
    end
    rst_n = 1'b0;
    @(negedge clock);
    chk("baud", 70'(BAUD_38400), 70'(baud_select));
    chk("pin0", 70'h1, 70'(io_pin[0]));
    rst_n = 1'b1;
    u_host.pulse();
    chk("preset", 70'h0, 70'(active_preset));
    chk("prof", {30'h2710, 30'h186A0, 10'h0C8}, active_profile);
    chk("eoff0", 70'hC350, 70'(axis_eff_offset[0]));
    chk("axis0", 70'(AX_DEF), 70'(axis_cfg[0]));
    summarize();
  end
endmodule
